// file: logic/alias_mailbox_gpio_freq_regs.sv
// Alias decoders, mailbox bytes, pin-nine/global pin config and pixel edge counter registers
//
// Contract
// RULE1 - Two seven-bit alias fields in bits 7..1 each steer a decoder for a remote target.
// RULE2 - A decoder hit forwards the transaction with the address from the target id register.
// RULE3 - An alias field of zero disables its decoder.
// RULE4 - Two free read/write mailbox bytes reset to 0x00 and 0x01.
// RULE5 - The global value drives every pin not individually enabled while global force output.
// RULE6 - Global {dir,en}: 00 functional out, 10 tri-state, 01 forced out, 11 forced in.
// RULE7 - Per-pin direction and enable override the global force bits.
// RULE8 - Pin-nine value reaches the pin only in GPIO output mode with remote control off.
// RULE9 - Pin-nine {dir,en}: 00 functional out, 10 tri-state, 01 GPIO out, 11 GPIO in.
// RULE10 - A write to the counter register starts counting pixel clock edges over an interval.
// RULE11 - The interval is the written value times the oscillator period of 50 ns; the code times it as TICK_CYCLES (2) cycles of the 40 ns clock, 80 ns per unit.
// RULE12 - A read of the counter register returns the edge count of the latest interval.
// RULE13 - The edge count saturates at 0xff.
// RULE14 - The host may use the count to estimate the oscillator or pixel clock rate.
// RULE15 - Each write to the counter register clears the previous count before counting.
module alias_mailbox_gpio_freq_regs
    import alias_mailbox_pkg::*;
#(
    parameter int N_PINS = 8
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // Register port
    input  wire logic              i_reg_wr,
    input  wire logic              i_reg_rd,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [7:0]        i_reg_wdata,
    output logic [7:0]             o_reg_rdata,
    output logic                   o_reg_rvalid,
    // Control bus transactions toward remote targets
    input  wire logic              i_txn_valid,
    input  wire logic [6:0]        i_txn_addr,
    input  wire logic [6:0]        i_target_id_sixth,
    input  wire logic [6:0]        i_target_id_seventh,
    output logic                   o_fwd_valid,
    output logic [6:0]             o_fwd_addr,
    // Pin nine
    input  wire logic              i_pin_nine_remote_en,
    input  wire logic              i_pin_nine_remote_level,
    input  wire logic              i_pin_nine_func_level,
    input  wire logic              i_pin_nine_in,
    output logic                   o_pin_nine_out,
    output logic                   o_pin_nine_oe_n,
    output logic                   o_pin_nine_level,
    // Other pins under global control
    input  wire logic [N_PINS-1:0] i_pin_local_cfg,
    input  wire logic [N_PINS-1:0] i_pin_func_level,
    output logic [N_PINS-1:0]      o_pin_global_out,
    output logic [N_PINS-1:0]      o_pin_global_oe_n,
    // Pixel clock, sampled as an ordinary input
    input  wire logic              i_pclk
);

    // Register state
    logic [6:0] alias_sixth_q,  alias_sixth_d;
    logic [6:0] alias_seventh_q, alias_seventh_d;
    logic [7:0] scratch_first_q, scratch_first_d;
    logic [7:0] scratch_second_q, scratch_second_d;
    logic [7:0] pin_cfg_q,      pin_cfg_d;
    logic [7:0] rdata_q,        rdata_d;
    logic       rvalid_q,       rvalid_d;

    logic wr_counter;
    assign wr_counter = i_reg_wr && (i_reg_addr == ADDR_EDGE_COUNTER);

    // Measurement state
    meas_state_t meas_q,  meas_d;
    logic [7:0]  ticks_left_q, ticks_left_d;
    logic [TICK_W-1:0] tick_div_q, tick_div_d;
    logic [7:0]  edges_q, edges_d;
    logic        pclk_prev_q, pclk_prev_d;

    // Register writes and reads; reads of the counter show the count, not the written value
    always_comb
    begin
        alias_sixth_d    = alias_sixth_q;
        alias_seventh_d  = alias_seventh_q;
        scratch_first_d  = scratch_first_q;
        scratch_second_d = scratch_second_q;
        pin_cfg_d        = pin_cfg_q;
        rdata_d          = rdata_q;
        rvalid_d         = i_reg_rd;
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                ADDR_ALIAS_SIXTH:    alias_sixth_d    = i_reg_wdata[ALIAS_LSB +: ALIAS_W]; // [RULE1]
                ADDR_ALIAS_SEVENTH:  alias_seventh_d  = i_reg_wdata[ALIAS_LSB +: ALIAS_W]; // [RULE1]
                ADDR_SCRATCH_FIRST:  scratch_first_d  = i_reg_wdata; // [RULE4]
                ADDR_SCRATCH_SECOND: scratch_second_d = i_reg_wdata; // [RULE4]
                ADDR_PIN_CONFIG:     pin_cfg_d        = i_reg_wdata & PIN_CONFIG_WMASK;
                default:             pin_cfg_d        = pin_cfg_q;
            endcase
        end
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                ADDR_ALIAS_SIXTH:    rdata_d = {alias_sixth_q, 1'b0};
                ADDR_ALIAS_SEVENTH:  rdata_d = {alias_seventh_q, 1'b0};
                ADDR_SCRATCH_FIRST:  rdata_d = scratch_first_q;
                ADDR_SCRATCH_SECOND: rdata_d = scratch_second_q;
                ADDR_PIN_CONFIG:     rdata_d = pin_cfg_q;
                ADDR_EDGE_COUNTER:   rdata_d = edges_q; // [RULE12]
                default:             rdata_d = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            alias_sixth_q    <= RST_ALIAS[ALIAS_LSB +: ALIAS_W];
            alias_seventh_q  <= RST_ALIAS[ALIAS_LSB +: ALIAS_W];
            scratch_first_q  <= RST_SCRATCH_FIRST;
            scratch_second_q <= RST_SCRATCH_SECOND; // [RULE4]
            pin_cfg_q        <= RST_PIN_CONFIG;
            rdata_q          <= READ_UNMAPPED;
            rvalid_q         <= 1'b0;
        end
        else
        begin
            alias_sixth_q    <= alias_sixth_d;
            alias_seventh_q  <= alias_seventh_d;
            scratch_first_q  <= scratch_first_d;
            scratch_second_q <= scratch_second_d;
            pin_cfg_q        <= pin_cfg_d;
            rdata_q          <= rdata_d;
            rvalid_q         <= rvalid_d;
        end
    end

    assign o_reg_rdata  = rdata_q;
    assign o_reg_rvalid = rvalid_q;

    // Alias decoders, one per alias register
    logic       hit_sixth, hit_seventh;
    logic [6:0] remap_sixth, remap_seventh;

    alias_decoder u_alias_sixth (
        .i_alias      (alias_sixth_q),
        .i_txn_valid  (i_txn_valid),
        .i_txn_addr   (i_txn_addr),
        .i_target_id  (i_target_id_sixth),
        .o_hit        (hit_sixth),
        .o_remap_addr (remap_sixth)
    );

    alias_decoder u_alias_seventh (
        .i_alias      (alias_seventh_q),
        .i_txn_valid  (i_txn_valid),
        .i_txn_addr   (i_txn_addr),
        .i_target_id  (i_target_id_seventh),
        .o_hit        (hit_seventh),
        .o_remap_addr (remap_seventh)
    );

    // Forwarding; if both aliases hold the same value the sixth wins
    logic       fwd_valid_q, fwd_valid_d;
    logic [6:0] fwd_addr_q,  fwd_addr_d;

    always_comb
    begin
        fwd_valid_d = hit_sixth || hit_seventh;
        fwd_addr_d  = fwd_addr_q;
        if (hit_sixth)
            fwd_addr_d = remap_sixth; // [RULE2]
        else if (hit_seventh)
            fwd_addr_d = remap_seventh; // [RULE2]
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            fwd_valid_q <= 1'b0;
            fwd_addr_q  <= ALIAS_OFF;
        end
        else
        begin
            fwd_valid_q <= fwd_valid_d;
            fwd_addr_q  <= fwd_addr_d;
        end
    end

    assign o_fwd_valid = fwd_valid_q;
    assign o_fwd_addr  = fwd_addr_q;

    // Pin drive decode
    logic [1:0] global_mode;
    logic [1:0] pin9_mode;
    assign global_mode = {pin_cfg_q[GLOBAL_DIR_BIT], pin_cfg_q[GLOBAL_EN_BIT]};
    assign pin9_mode   = {pin_cfg_q[PIN9_DIR_BIT], pin_cfg_q[PIN9_EN_BIT]};

    logic              p9_out_q,  p9_out_d;
    logic              p9_oen_q,  p9_oen_d;
    logic              p9_lvl_q,  p9_lvl_d;
    logic [N_PINS-1:0] g_out_q,   g_out_d;
    logic [N_PINS-1:0] g_oen_q,   g_oen_d;

    always_comb
    begin
        // Pin nine: its own setting outranks the global force bits [RULE7]
        p9_out_d = 1'b0;
        p9_oen_d = 1'b1;
        case (pin9_mode) // [RULE9]
            MODE_FUNC_OUT:
            begin
                // Functional mode leaves the pin open to the global force bits
                case (global_mode) // [RULE6]
                    MODE_FUNC_OUT:
                    begin
                        p9_out_d = i_pin_nine_func_level;
                        p9_oen_d = 1'b0;
                    end
                    MODE_GPIO_OUT:
                    begin
                        p9_out_d = pin_cfg_q[GLOBAL_VALUE_BIT]; // [RULE5]
                        p9_oen_d = 1'b0;
                    end
                    default:
                    begin
                        p9_out_d = 1'b0;
                        p9_oen_d = 1'b1;
                    end
                endcase
            end
            MODE_GPIO_OUT:
            begin
                // Remote control takes the pin away from the local value [RULE8]
                p9_out_d = i_pin_nine_remote_en ? i_pin_nine_remote_level
                                                : pin_cfg_q[PIN9_VALUE_BIT];
                p9_oen_d = 1'b0;
            end
            MODE_TRISTATE, MODE_GPIO_IN:
            begin
                p9_out_d = 1'b0;
                p9_oen_d = 1'b1;
            end
            default:
            begin
                p9_out_d = 1'b0;
                p9_oen_d = 1'b1;
            end
        endcase
        p9_lvl_d = i_pin_nine_in;

        // Other pins obey the global bits only when not locally configured [RULE7]
        for (int i = 0; i < N_PINS; i++)
        begin
            g_out_d[i] = 1'b0;
            g_oen_d[i] = 1'b1;
            if (!i_pin_local_cfg[i])
            begin
                case (global_mode) // [RULE6]
                    MODE_FUNC_OUT:
                    begin
                        g_out_d[i] = i_pin_func_level[i];
                        g_oen_d[i] = 1'b0;
                    end
                    MODE_GPIO_OUT:
                    begin
                        g_out_d[i] = pin_cfg_q[GLOBAL_VALUE_BIT]; // [RULE5]
                        g_oen_d[i] = 1'b0;
                    end
                    default:
                    begin
                        g_out_d[i] = 1'b0;
                        g_oen_d[i] = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            p9_out_q <= 1'b0;
            p9_oen_q <= 1'b1;
            p9_lvl_q <= 1'b0;
            g_out_q  <= '0;
            g_oen_q  <= '1;
        end
        else
        begin
            p9_out_q <= p9_out_d;
            p9_oen_q <= p9_oen_d;
            p9_lvl_q <= p9_lvl_d;
            g_out_q  <= g_out_d;
            g_oen_q  <= g_oen_d;
        end
    end

    assign o_pin_nine_out    = p9_out_q;
    assign o_pin_nine_oe_n   = p9_oen_q;
    assign o_pin_nine_level  = p9_lvl_q;
    assign o_pin_global_out  = g_out_q;
    assign o_pin_global_oe_n = g_oen_q;

    // Pixel edge measurement; only rising edges are seen, so the pixel clock must stay
    // at or below half the sampling rate for the count to mean anything
    logic pclk_rise;
    logic tick_end;
    assign pclk_rise = i_pclk && !pclk_prev_q;
    assign tick_end  = (tick_div_q == TICK_W'(TICK_CYCLES - 1));

    always_comb
    begin
        meas_d       = meas_q;
        ticks_left_d = ticks_left_q;
        tick_div_d   = tick_div_q;
        edges_d      = edges_q;
        pclk_prev_d  = i_pclk;
        case (meas_q)
            MEAS_IDLE:
            begin
                tick_div_d = '0;
            end
            MEAS_RUN:
            begin
                if (pclk_rise && (edges_q != EDGE_COUNT_MAX))
                    edges_d = edges_q + 8'h01; // [RULE13]
                tick_div_d = tick_end ? '0 : tick_div_q + TICK_W'(1);
                if (tick_end)
                begin
                    ticks_left_d = ticks_left_q - 8'h01; // [RULE11]
                    if (ticks_left_q == 8'h01)
                        meas_d = MEAS_IDLE;
                end
            end
            default:
            begin
                meas_d = MEAS_IDLE;
            end
        endcase
        // A write restarts the interval from a zero count; zero means no interval
        if (wr_counter)
        begin
            edges_d      = RST_EDGE_COUNTER; // [RULE15]
            ticks_left_d = i_reg_wdata; // [RULE11]
            tick_div_d   = '0;
            meas_d       = (i_reg_wdata != 8'h00) ? MEAS_RUN : MEAS_IDLE; // [RULE10]
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            meas_q       <= MEAS_IDLE;
            ticks_left_q <= RST_EDGE_COUNTER;
            tick_div_q   <= '0;
            edges_q      <= RST_EDGE_COUNTER;
            pclk_prev_q  <= 1'b0;
        end
        else
        begin
            meas_q       <= meas_d;
            ticks_left_q <= ticks_left_d;
            tick_div_q   <= tick_div_d;
            edges_q      <= edges_d;
            pclk_prev_q  <= pclk_prev_d;
        end
    end

endmodule

// file: logic/alias_mailbox_pkg.sv
// Package with register map, field layout, reset values and timing for the alias/mailbox bank
package alias_mailbox_pkg;

    // Register offsets on the serial control bus
    localparam logic [7:0] ADDR_ALIAS_SIXTH   = 8'h16;
    localparam logic [7:0] ADDR_ALIAS_SEVENTH = 8'h17;
    localparam logic [7:0] ADDR_SCRATCH_FIRST = 8'h18;
    localparam logic [7:0] ADDR_SCRATCH_SECOND = 8'h19;
    localparam logic [7:0] ADDR_PIN_CONFIG    = 8'h1a;
    localparam logic [7:0] ADDR_EDGE_COUNTER  = 8'h1b;

    // Reset values
    localparam logic [7:0] RST_ALIAS          = 8'h00;
    localparam logic [7:0] RST_SCRATCH_FIRST  = 8'h00;
    localparam logic [7:0] RST_SCRATCH_SECOND = 8'h01;
    localparam logic [7:0] RST_PIN_CONFIG     = 8'h00;
    localparam logic [7:0] RST_EDGE_COUNTER   = 8'h00;
    localparam logic [7:0] READ_UNMAPPED      = 8'h00;

    // Alias field sits in bits 7..1, bit 0 reads zero
    localparam int         ALIAS_LSB          = 1;
    localparam int         ALIAS_W            = 7;
    localparam logic [6:0] ALIAS_OFF          = 7'h00;

    // Pin configuration register fields
    localparam int GLOBAL_VALUE_BIT = 7;
    localparam int GLOBAL_DIR_BIT   = 5;
    localparam int GLOBAL_EN_BIT    = 4;
    localparam int PIN9_VALUE_BIT   = 3;
    localparam int PIN9_DIR_BIT     = 1;
    localparam int PIN9_EN_BIT      = 0;
    localparam logic [7:0] PIN_CONFIG_WMASK = 8'hbb;

    // {direction, enable} encodings
    localparam logic [1:0] MODE_FUNC_OUT  = 2'h0;
    localparam logic [1:0] MODE_TRISTATE  = 2'h2;
    localparam logic [1:0] MODE_GPIO_OUT  = 2'h1;
    localparam logic [1:0] MODE_GPIO_IN   = 2'h3;

    // Edge counter saturation and interval timing
    localparam logic [7:0] EDGE_COUNT_MAX = 8'hff;
    localparam int         MCLK_PERIOD_NS = 40;
    localparam int         OSC_PERIOD_NS  = 50;
    // Interval unit rounded up to whole clock cycles, never below one
    localparam int         TICK_CYCLES_RAW =
        (OSC_PERIOD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int         TICK_CYCLES    = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
    localparam int         TICK_W         = 4;

    // Measurement state
    typedef enum logic [0:0] {
        MEAS_IDLE,
        MEAS_RUN
    } meas_state_t;

endpackage

// file: logic/alias_decoder.sv
// One remote-target alias decoder: match an address and return the remapped target
module alias_decoder
    import alias_mailbox_pkg::*;
(
    input  wire logic [6:0] i_alias,
    input  wire logic       i_txn_valid,
    input  wire logic [6:0] i_txn_addr,
    input  wire logic [6:0] i_target_id,
    output logic            o_hit,
    output logic [6:0]      o_remap_addr
);

    // A zero alias never matches, so the decoder is off [RULE3]
    assign o_hit        = i_txn_valid && (i_alias != ALIAS_OFF) && (i_txn_addr == i_alias); // [RULE1]
    // Remapped address comes from the target identifier register [RULE2]
    assign o_remap_addr = i_target_id;

endmodule

// file: testbench/alias_mailbox_properties.sv
// Port assertions for the alias, mailbox, pin and edge counter bank
module alias_mailbox_props
#(
    parameter int N_PINS = 8
)
(
    input wire logic              i_mclk,
    input wire logic              i_rst,
    input wire logic              i_reg_wr,
    input wire logic              i_reg_rd,
    input wire logic [7:0]        i_reg_addr,
    input wire logic [7:0]        i_reg_wdata,
    input wire logic [7:0]        o_reg_rdata,
    input wire logic              o_reg_rvalid,
    input wire logic              i_txn_valid,
    input wire logic [6:0]        i_txn_addr,
    input wire logic [6:0]        i_target_id_sixth,
    input wire logic [6:0]        i_target_id_seventh,
    input wire logic              o_fwd_valid,
    input wire logic [6:0]        o_fwd_addr,
    input wire logic              i_pin_nine_remote_en,
    input wire logic              o_pin_nine_out,
    input wire logic              o_pin_nine_oe_n,
    input wire logic [N_PINS-1:0] i_pin_local_cfg,
    input wire logic [N_PINS-1:0] i_pin_func_level,
    input wire logic [N_PINS-1:0] o_pin_global_out,
    input wire logic [N_PINS-1:0] o_pin_global_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import alias_mailbox_pkg::*;
    logic [7:0] cfg_q, cfg_d, mb_q, mb_d, v_q, v_d;
    logic       rst_q;

    default clocking dc @(posedge i_mclk);
    endclocking
    // Reset held a cycle longer: outputs lag its release
    default disable iff (i_rst || rst_q);

    // Shadows of host writes
    always_comb
    begin
        cfg_d = cfg_q;
        mb_d = mb_q;
        v_d = v_q;
        if (i_reg_wr && i_reg_addr == ADDR_PIN_CONFIG) cfg_d = i_reg_wdata & PIN_CONFIG_WMASK;
        if (i_reg_wr && i_reg_addr == ADDR_SCRATCH_SECOND) mb_d = i_reg_wdata;
        if (i_reg_wr && i_reg_addr == ADDR_EDGE_COUNTER) v_d = i_reg_wdata;
    end
    // Shadow resets
    always_ff @(posedge i_mclk)
    begin
        rst_q <= i_rst;
        cfg_q <= i_rst ? RST_PIN_CONFIG : cfg_d;
        mb_q <= i_rst ? RST_SCRATCH_SECOND : mb_d;
        v_q <= i_rst ? 8'h00 : v_d;
    end

    chk_mbox_readback: assert property (
        (i_reg_rd && i_reg_addr == ADDR_SCRATCH_SECOND)
        |=> o_reg_rvalid && o_reg_rdata == $past(mb_q))
        else $error("mailbox readback wrong");
    chk_alias_low_zero: assert property (
        (i_reg_rd && (i_reg_addr == ADDR_ALIAS_SIXTH || i_reg_addr == ADDR_ALIAS_SEVENTH))
        |=> o_reg_rdata[0] == 1'b0)
        else $error("alias bit0 set");
    chk_fwd_cause: assert property (
        o_fwd_valid |-> $past(i_txn_valid) && (o_fwd_addr == $past(i_target_id_sixth)
        || o_fwd_addr == $past(i_target_id_seventh)))
        else $error("stray forward");
    chk_zero_no_fwd: assert property (
        (i_txn_valid && i_txn_addr == 7'h00) |=> !o_fwd_valid)
        else $error("zero address forwarded");
    chk_count_bound: assert property (
        (i_reg_rd && i_reg_addr == ADDR_EDGE_COUNTER)
        |=> int'(o_reg_rdata) <= (int'($past(v_q)) * TICK_CYCLES + 1) / 2)
        else $error("count over bound");
    chk_pin9_release: assert property (
        cfg_q[PIN9_DIR_BIT] |=> o_pin_nine_oe_n)
        else $error("pin nine not released");
    chk_pin9_local: assert property (
        (cfg_q[1:0] == MODE_GPIO_OUT && !i_pin_nine_remote_en)
        |=> !o_pin_nine_oe_n && o_pin_nine_out == $past(cfg_q[PIN9_VALUE_BIT]))
        else $error("pin nine value wrong");
    chk_global_forced: assert property (
        (cfg_q[5:4] == MODE_GPIO_OUT) |=> o_pin_global_oe_n == $past(i_pin_local_cfg)
        && ((o_pin_global_out ^ {N_PINS{$past(cfg_q[7])}}) & ~$past(i_pin_local_cfg)) == '0)
        else $error("forced value wrong");
    chk_global_func: assert property (
        (cfg_q[5:4] == MODE_FUNC_OUT) |=> o_pin_global_oe_n == $past(i_pin_local_cfg)
        && ((o_pin_global_out ^ $past(i_pin_func_level)) & ~$past(i_pin_local_cfg)) == '0)
        else $error("functional level wrong");
    chk_global_release: assert property (
        cfg_q[GLOBAL_DIR_BIT] |=> &o_pin_global_oe_n)
        else $error("pins not released");

    cover property (o_fwd_valid);
    cover property ((i_reg_rd && i_reg_addr == ADDR_EDGE_COUNTER) ##1 o_reg_rdata == 8'hff);
    cover property (cfg_q[1:0] == MODE_GPIO_OUT && i_pin_nine_remote_en);
endmodule

// file: testbench/pixel_clock_source.sv
// Pixel clock source for the far side
module pixel_clock_source (
    input  wire logic       i_mclk,
    input  wire logic [1:0] i_half,
    output logic            o_pclk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] n_q = 2'h0;
    logic [1:0] n_d;
    logic       p_q = 1'b0;
    logic       p_d;

    // Toggle every i_half cycles; zero parks it low
    always_comb
    begin
        n_d = n_q + 2'h1;
        p_d = p_q;
        if (i_half == 2'h0) p_d = 1'b0;
        else if (n_d >= i_half) p_d = ~p_q;
        if (n_d >= i_half) n_d = 2'h0;
    end
    // No reset: it need only run before a measurement
    always_ff @(posedge i_mclk)
    begin
        n_q <= n_d;
        p_q <= p_d;
    end
    assign o_pclk = p_q;
endmodule

// file: testbench/tb_alias_mailbox_gpio_freq_regs.sv
// Bench for the alias, mailbox, pin and edge counter bank
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_alias_mailbox_gpio_freq_regs
    import alias_mailbox_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 8;
    logic          i_mclk = 1'b0;
    logic          i_rst = 1'b1;
    logic          i_reg_wr = 1'b0;
    logic          i_reg_rd = 1'b0;
    logic [7:0]    i_reg_addr = 8'h00;
    logic [7:0]    i_reg_wdata = 8'h00;
    logic          i_txn_valid = 1'b0;
    logic [6:0]    i_txn_addr = 7'h00;
    logic [6:0]    i_target_id_sixth = 7'h50;
    logic [6:0]    i_target_id_seventh = 7'h60;
    logic          i_pin_nine_remote_en = 1'b0;
    logic          i_pin_nine_remote_level = 1'b0;
    logic          i_pin_nine_func_level = 1'b1;
    logic          i_pin_nine_in = 1'b0;
    logic [NP-1:0] i_pin_local_cfg = 8'h0f;
    logic [NP-1:0] i_pin_func_level = 8'h96;
    logic          i_pclk;
    logic [1:0]    half = 2'h2;
    logic [7:0]    o_reg_rdata;
    logic          o_reg_rvalid;
    logic          o_fwd_valid;
    logic [6:0]    o_fwd_addr;
    logic          o_pin_nine_out;
    logic          o_pin_nine_oe_n;
    logic          o_pin_nine_level;
    logic [NP-1:0] o_pin_global_out;
    logic [NP-1:0] o_pin_global_oe_n;
    logic [7:0]    ge, ex;
    logic [7:0]    rst_tab [7] = '{RST_ALIAS, RST_ALIAS, RST_SCRATCH_FIRST,
        RST_SCRATCH_SECOND, RST_PIN_CONFIG, RST_EDGE_COUNTER, READ_UNMAPPED};
    int            err_total = 0;
    int            n_compared = 0;
    int            cyc = 0;

    alias_mailbox_gpio_freq_regs #(.N_PINS(NP)) u_dut (
        .i_mclk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
        .o_reg_rvalid, .i_txn_valid, .i_txn_addr, .i_target_id_sixth, .i_target_id_seventh,
        .o_fwd_valid, .o_fwd_addr, .i_pin_nine_remote_en, .i_pin_nine_remote_level,
        .i_pin_nine_func_level, .i_pin_nine_in, .o_pin_nine_out, .o_pin_nine_oe_n,
        .o_pin_nine_level, .i_pin_local_cfg, .i_pin_func_level, .o_pin_global_out,
        .o_pin_global_oe_n, .i_pclk
    );
    pixel_clock_source u_pix (.i_mclk, .i_half(half), .o_pclk(i_pclk));

    always #20 i_mclk = ~i_mclk;

    // Hang limit
    always @(posedge i_mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic test_done();
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Write: strobe seen at one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask

    // Read: checked in the one rvalid cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        `CHK("rvalid", 1'b1, o_reg_rvalid)
        `CHK("rdata", e, o_reg_rdata)
    endtask

    // Transaction; forward checked a cycle later
    task automatic txn(input logic [6:0] a, input logic hit, input logic [6:0] e);
        @(posedge i_mclk);
        i_txn_valid <= 1'b1;
        i_txn_addr <= a;
        @(posedge i_mclk);
        i_txn_valid <= 1'b0;
        #1;
        `CHK("fwd_valid", hit, o_fwd_valid)
        if (hit) `CHK("fwd_addr", e, o_fwd_addr)
    endtask

    task automatic settle();
        @(posedge i_mclk);
        #1;
    endtask

    // Count run: write, wait out, read
    task automatic meas(input logic [7:0] v, input logic [7:0] e);
        wr(ADDR_EDGE_COUNTER, v);
        repeat (int'(v) * TICK_CYCLES + 2) @(posedge i_mclk);
        rd(ADDR_EDGE_COUNTER, e);
    endtask

    initial
    begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        // Reset values, then an unmapped offset
        for (int k = 0; k < 7; k++)
            rd(ADDR_ALIAS_SIXTH + 8'(k), rst_tab[k]);
        wr(ADDR_SCRATCH_FIRST, 8'ha5);
        wr(ADDR_SCRATCH_SECOND, 8'h5a);
        rd(ADDR_SCRATCH_FIRST, 8'ha5);
        rd(ADDR_SCRATCH_SECOND, 8'h5a);
        // Aliases: bit0 reserved, hits, a miss, disabled
        wr(ADDR_ALIAS_SIXTH, 8'hff);
        rd(ADDR_ALIAS_SIXTH, 8'hfe);
        wr(ADDR_ALIAS_SIXTH, {7'h15, 1'b0});
        wr(ADDR_ALIAS_SEVENTH, {7'h33, 1'b0});
        txn(7'h15, 1'b1, 7'h50);
        txn(7'h33, 1'b1, 7'h60);
        txn(7'h44, 1'b0, 7'h00);
        wr(ADDR_ALIAS_SIXTH, 8'h00);
        txn(7'h15, 1'b0, 7'h00);
        txn(7'h00, 1'b0, 7'h00);
        // Every global mode, pin nine functional
        for (int g = 0; g < 4; g++)
        begin
            wr(ADDR_PIN_CONFIG, 8'h80 | 8'(g << 4));
            settle();
            ge = g[1] ? 8'hff : i_pin_local_cfg;
            ex = (g == 0) ? i_pin_func_level : 8'hff;
            `CHK("glob_oe", ge, o_pin_global_oe_n)
            `CHK("glob_out", ex & ~ge, o_pin_global_out & ~ge)
            `CHK("p9_oe", g[1], o_pin_nine_oe_n)
            if (!g[1]) `CHK("p9_out", 1'b1, o_pin_nine_out)
        end
        // Pin nine's own level beats a forced global low
        wr(ADDR_PIN_CONFIG, 8'h19);
        settle();
        `CHK("p9_oe", 1'b0, o_pin_nine_oe_n)
        `CHK("p9_out", 1'b1, o_pin_nine_out)
        @(posedge i_mclk);
        i_pin_nine_remote_en <= 1'b1;
        settle();
        `CHK("p9_out", 1'b0, o_pin_nine_out)
        @(posedge i_mclk);
        i_pin_nine_remote_level <= 1'b1;
        settle();
        `CHK("p9_out", 1'b1, o_pin_nine_out)
        for (int h = 2; h < 4; h++)
        begin
            wr(ADDR_PIN_CONFIG, 8'h10 | 8'(h));
            i_pin_nine_in <= h[0];
            settle();
            `CHK("p9_oe", 1'b1, o_pin_nine_oe_n)
            `CHK("p9_level", h[0], o_pin_nine_level)
        end
        wr(ADDR_PIN_CONFIG, 8'hff);
        rd(ADDR_PIN_CONFIG, PIN_CONFIG_WMASK);
        // Counter: slow, zero, full, parked, restart
        meas(8'd10, 8'(10 * TICK_CYCLES / 4));
        @(posedge i_mclk);
        half <= 2'h1;
        meas(8'd0, 8'h00);
        meas(8'd255, EDGE_COUNT_MAX);
        @(posedge i_mclk);
        half <= 2'h0;
        meas(8'd5, 8'h00);
        @(posedge i_mclk);
        half <= 2'h1;
        wr(ADDR_EDGE_COUNTER, 8'd200);
        repeat (10) @(posedge i_mclk);
        meas(8'd3, 8'd3);
        test_done();
    end
endmodule

bind alias_mailbox_gpio_freq_regs alias_mailbox_props #(.N_PINS(N_PINS)) u_props (
    .i_mclk, .i_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
    .o_reg_rvalid, .i_txn_valid, .i_txn_addr, .i_target_id_sixth, .i_target_id_seventh,
    .o_fwd_valid, .o_fwd_addr, .i_pin_nine_remote_en, .o_pin_nine_out, .o_pin_nine_oe_n,
    .i_pin_local_cfg, .i_pin_func_level, .o_pin_global_out, .o_pin_global_oe_n
);
